// [include/sio_pkg.sv]
// Constants, types and the local register map of the serial 8-bit I/O port.
// Assumes a single 50 MHz system clock; all link pins are sampled by it.
// Functional notes
// - An access is a control byte, then a data byte for data or direction register.
// - Control byte picks target register, direction, compare condition and data/mask format.
// - A written byte may act as a set mask or clear mask.
// - Direction bit 0 makes a pin input; 1 drives its data bit out.
// - Data read returns buffered pin level for input pins.
// - Data read returns last written value for output pins.
// - After reset all pins are inputs, direction register cleared.
// - First two bits must match the identify inputs, else device stays out.
// - Compare flag latched at chip enable fall, identify match or not.
// - Input pins are compared against their data register bits.
// - Output pins count as equal to their data register bits.
// - Mode 00 any mismatch, 01 all match, 10 all mismatch, 11 any match.
// - Flag is 1 when the chosen condition holds, else 0.
// - Idle serial clock level latched at select picks sample and shift edges.
// - Compare flag is shifted out during the control byte once the two identify bits match.
// - Control byte: ident hi, ident lo, target, write, format hi/lo, compare hi/lo.
// - Write format 0x replaces, 10 clears masked bits, 11 sets masked bits.
// - Write byte shifts out old value, then output floats and register updates.
// - Bits move MSB first, one clock each, in groups of eight.
package sio_pkg;

    // ==========================================
    // Local register port map
    localparam logic [1:0] SIO_OFS_DATA = 2'h0;
    localparam logic [1:0] SIO_OFS_DIR = 2'h1;
    localparam logic [1:0] SIO_OFS_STAT = 2'h2;
    localparam logic [1:0] SIO_OFS_CTL = 2'h3;

    // ==========================================
    // Reset values
    localparam logic [7:0] SIO_DATA_RST = 8'h00;
    localparam logic [7:0] SIO_DIR_RST = 8'h00;
    localparam logic SIO_EN_RST = 1'b1;

    // ==========================================
    // Field positions
    localparam int SIO_CTL_EN_BIT = 0;
    localparam int SIO_STAT_FLAG_BIT = 0;
    localparam int SIO_STAT_CPOL_BIT = 1;
    localparam int SIO_STAT_IDOK_BIT = 2;
    localparam int SIO_STAT_DATA_BIT = 3;
    localparam logic [2:0] SIO_LAST_BIT = 3'h7;
    localparam logic [2:0] SIO_IDENT_DONE_BIT = 3'h1;

    // ==========================================
    // Compare conditions and write formats
    localparam logic [1:0] SIO_CMP_ANY_MISS = 2'h0;
    localparam logic [1:0] SIO_CMP_ALL_HIT = 2'h1;
    localparam logic [1:0] SIO_CMP_ALL_MISS = 2'h2;
    localparam logic [1:0] SIO_CMP_ANY_HIT = 2'h3;
    localparam logic [1:0] SIO_FMT_CLEAR = 2'h2;
    localparam logic [1:0] SIO_FMT_SET = 2'h3;

    // Control byte, MSB first on the wire
    typedef struct packed {
        logic [1:0] chip_ident;
        logic target_select;
        logic write;
        logic write_format_hi;
        logic write_format_lo;
        logic compare_cond_hi;
        logic compare_cond_lo;
    } sio_ctrl_t;

    typedef enum logic [3:0] {
        SIO_ST_IDLE = 4'h1,
        SIO_ST_CTRL = 4'h2,
        SIO_ST_DATA = 4'h4,
        SIO_ST_DONE = 4'h8
    } sio_state_t;

endpackage

// [verilog/sio_sync.sv]
// Three-flop input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk; output moves once stages 2 and 3 agree.
`timescale 1ns/1ps
module sio_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    wire [W-1:0] agree = ~(s2_r ^ s3_r);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            dout <= INIT;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= (s3_r & agree) | (dout & ~agree);
        end
    end
endmodule

// [verilog/sio_compare.sv]
// Pin-against-latch comparator with four selectable conditions.
// Assumes pins are already synchronised to clk.
`timescale 1ns/1ps
module sio_compare (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] pins,
    input wire logic [7:0] latch,
    input wire logic [7:0] dir,
    input wire logic [1:0] mode,
    output logic hit
);
    // Outputs are taken as equal by definition
    wire [7:0] eq = ~((pins ^ latch) & ~dir);
    wire all_eq = &eq;
    wire any_eq = |eq;

    always_comb begin
        unique case (mode)
            sio_pkg::SIO_CMP_ANY_MISS: hit = ~all_eq;
            sio_pkg::SIO_CMP_ALL_HIT: hit = all_eq;
            sio_pkg::SIO_CMP_ALL_MISS: hit = ~any_eq;
            sio_pkg::SIO_CMP_ANY_HIT: hit = any_eq;
        endcase
    end

    cond_all_a: assert property (@(posedge clk) disable iff (sys_rst)
        (mode == sio_pkg::SIO_CMP_ALL_HIT) |-> (hit == ((~(pins ^ latch) | dir) == 8'hff)))
        else $error("all-match condition wrong");
endmodule

// [verilog/sio_port.sv]
// Serial 8-bit I/O port: SPI slave, data and direction latches, comparator.
// Assumes a clock-phase-1 master; all link pins arrive asynchronous to clk.
`timescale 1ns/1ps
module sio_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic mosi,
    input wire logic ce_n,
    input wire logic chip_ident_msb,
    input wire logic chip_ident_lsb,
    output logic miso_o,
    output logic miso_oe,
    input wire logic [7:0] port_pins_i,
    output logic [7:0] port_pins_o,
    output logic [7:0] port_pins_oe,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    // ==========================================
    // Input synchronisers
    logic sck_f;
    logic mosi_f;
    logic ce_n_f;
    logic [1:0] ident_f;
    logic [7:0] pins_f;

    sio_sync #(.W(1), .INIT(1'b0)) u_sync_sck (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(sck),
        .dout(sck_f)
    );
    sio_sync #(.W(1), .INIT(1'b0)) u_sync_mosi (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(mosi),
        .dout(mosi_f)
    );
    // Reset to deselected so no false select follows reset
    sio_sync #(.W(1), .INIT(1'b1)) u_sync_ce (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(ce_n),
        .dout(ce_n_f)
    );
    sio_sync #(.W(2), .INIT(2'h0)) u_sync_id (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({chip_ident_msb, chip_ident_lsb}),
        .dout(ident_f)
    );
    sio_sync #(.W(8), .INIT(8'h00)) u_sync_pins (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(port_pins_i),
        .dout(pins_f)
    );

    // ==========================================
    // State
    sio_pkg::sio_state_t st_r;
    sio_pkg::sio_state_t st_nxt;
    logic [7:0] data_r;
    logic [7:0] dir_r;
    logic [7:0] sh_in_r;
    logic [7:0] sh_out_r;
    logic [7:0] sh_out_nxt;
    logic [2:0] bit_cnt_r;
    logic [2:0] bit_cnt_nxt;
    logic sel_d_r;
    logic sck_d_r;
    logic cpol_r;
    logic flag_r;
    logic id_ok_r;
    logic tgt_dir_r;
    logic wr_r;
    logic [1:0] fmt_r;
    logic [1:0] cmp_mode_r;
    logic ctl_en_r;
    logic cmp_hit;

    // ==========================================
    // Link decode
    wire sel = ~ce_n_f & ctl_en_r;
    wire ce_fall = sel & ~sel_d_r;
    wire sck_chg = sck_f ^ sck_d_r;
    // Leading edge leaves the idle level, trailing returns to it
    wire lead = sck_chg & (sck_d_r == cpol_r);
    wire trail = sck_chg & (sck_f == cpol_r);
    wire in_ctrl = (st_r == sio_pkg::SIO_ST_CTRL);
    wire in_data = (st_r == sio_pkg::SIO_ST_DATA);
    wire [7:0] sh_in_nxt = {sh_in_r[6:0], mosi_f};
    wire last_bit = (bit_cnt_r == sio_pkg::SIO_LAST_BIT);
    wire ctrl_done = in_ctrl & trail & last_bit;
    wire data_done = in_data & trail & last_bit;
    wire sio_pkg::sio_ctrl_t ctrl = sio_pkg::sio_ctrl_t'(sh_in_nxt);
    wire id_hit = (ctrl.chip_ident == ident_f);
    wire id_early = ({sh_in_r[0], mosi_f} == ident_f);
    wire id_step = in_ctrl & trail & (bit_cnt_r == sio_pkg::SIO_IDENT_DONE_BIT);

    // ==========================================
    // Register values seen by the link
    wire [7:0] rd_val = (data_r & dir_r) | (pins_f & ~dir_r);
    wire [7:0] new_tgt = ctrl.target_select ? dir_r : rd_val;
    wire [7:0] cur_tgt = tgt_dir_r ? dir_r : rd_val;
    wire [7:0] old_lat = tgt_dir_r ? dir_r : data_r;
    wire [7:0] wr_val = ~fmt_r[1] ? sh_in_nxt :
                        (fmt_r == sio_pkg::SIO_FMT_SET) ? (old_lat | sh_in_nxt) :
                        (old_lat & ~sh_in_nxt);
    wire wr_fire = data_done & wr_r;
    wire [7:0] data_nxt = (wr_fire & ~tgt_dir_r) ? wr_val : data_r;
    wire [7:0] dir_nxt = (wr_fire & tgt_dir_r) ? wr_val : dir_r;
    wire drive_ctrl = lead & in_ctrl & id_ok_r;
    wire drive_data = lead & in_data;

    // ==========================================
    // Sequencer
    always_comb begin
        st_nxt = st_r;
        if (!sel) begin
            st_nxt = sio_pkg::SIO_ST_IDLE;
        end else begin
            unique case (st_r)
                sio_pkg::SIO_ST_IDLE: begin
                    if (ce_fall) begin
                        st_nxt = sio_pkg::SIO_ST_CTRL;
                    end
                end
                sio_pkg::SIO_ST_CTRL: begin
                    if (ctrl_done) begin
                        st_nxt = id_hit ? sio_pkg::SIO_ST_DATA : sio_pkg::SIO_ST_DONE;
                    end
                end
                sio_pkg::SIO_ST_DATA: begin
                    if (wr_fire) begin
                        st_nxt = sio_pkg::SIO_ST_DONE;
                    end
                end
                sio_pkg::SIO_ST_DONE: begin
                    st_nxt = sio_pkg::SIO_ST_DONE;
                end
                default: begin
                    st_nxt = sio_pkg::SIO_ST_IDLE;
                end
            endcase
        end
    end

    assign bit_cnt_nxt = (!(in_ctrl | in_data) || !sel) ? 3'h0 :
                         trail ? bit_cnt_r + 3'h1 : bit_cnt_r;

    // Read keeps reloading so the register streams while selected
    assign sh_out_nxt = ctrl_done ? new_tgt :
                        (data_done & ~wr_r) ? cur_tgt :
                        drive_data ? {sh_out_r[6:0], 1'b0} : sh_out_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= sio_pkg::SIO_ST_IDLE;
            bit_cnt_r <= 3'h0;
            sh_in_r <= 8'h00;
            sh_out_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            sh_in_r <= trail ? sh_in_nxt : sh_in_r;
            sh_out_r <= sh_out_nxt;
        end
    end

    // ==========================================
    // Select-time captures
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_d_r <= 1'b0;
            sck_d_r <= 1'b0;
            cpol_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            sel_d_r <= sel;
            sck_d_r <= sck_f;
            cpol_r <= ce_fall ? sck_f : cpol_r;
            flag_r <= ce_fall ? cmp_hit : flag_r;
        end
    end

    // ==========================================
    // Control byte fields
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            id_ok_r <= 1'b0;
            tgt_dir_r <= 1'b0;
            wr_r <= 1'b0;
            fmt_r <= 2'h0;
            cmp_mode_r <= sio_pkg::SIO_CMP_ANY_MISS;
        end else begin
            id_ok_r <= !sel ? 1'b0 : id_step ? id_early : id_ok_r;
            if (ctrl_done && id_hit) begin
                tgt_dir_r <= ctrl.target_select;
                wr_r <= ctrl.write;
                fmt_r <= {ctrl.write_format_hi, ctrl.write_format_lo};
                cmp_mode_r <= {ctrl.compare_cond_hi, ctrl.compare_cond_lo};
            end
        end
    end

    // ==========================================
    // Port latches, driven straight to the pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_r <= sio_pkg::SIO_DATA_RST;
            dir_r <= sio_pkg::SIO_DIR_RST;
            port_pins_o <= sio_pkg::SIO_DATA_RST;
            port_pins_oe <= sio_pkg::SIO_DIR_RST;
        end else begin
            data_r <= data_nxt;
            dir_r <= dir_nxt;
            port_pins_o <= data_nxt;
            port_pins_oe <= dir_nxt;
        end
    end

    // ==========================================
    // Serial output
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            miso_o <= 1'b0;
            miso_oe <= 1'b0;
        end else begin
            miso_o <= drive_ctrl ? flag_r : drive_data ? sh_out_r[7] : miso_o;
            if (!sel || wr_fire || (ctrl_done && !id_hit)) begin
                miso_oe <= 1'b0;
            end else if (drive_ctrl || drive_data) begin
                miso_oe <= 1'b1;
            end
        end
    end

    sio_compare u_cmp (
        .clk(clk),
        .sys_rst(sys_rst),
        .pins(pins_f),
        .latch(data_r),
        .dir(dir_r),
        .mode(cmp_mode_r),
        .hit(cmp_hit)
    );

    // ==========================================
    // Local register port
    wire [7:0] stat_val = {4'h0, in_data, id_ok_r, cpol_r, flag_r};
    wire [7:0] rd_mux = (reg_addr == sio_pkg::SIO_OFS_DATA) ? rd_val :
                        (reg_addr == sio_pkg::SIO_OFS_DIR) ? dir_r :
                        (reg_addr == sio_pkg::SIO_OFS_STAT) ? stat_val :
                        {7'h0, ctl_en_r};
    wire ctl_we = reg_wr & (reg_addr == sio_pkg::SIO_OFS_CTL);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_en_r <= sio_pkg::SIO_EN_RST;
            reg_rdata <= 8'h00;
        end else begin
            ctl_en_r <= ctl_we ? reg_wdata[sio_pkg::SIO_CTL_EN_BIT] : ctl_en_r;
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ==========================================
    // Checks
    dir_reset_a: assert property (@(posedge clk)
        sys_rst |=> (port_pins_oe == 8'h00))
        else $error("pins not inputs after reset");

    desel_float_a: assert property (@(posedge clk) disable iff (sys_rst)
        !sel |=> !miso_oe)
        else $error("serial output driven while deselected");

    flag_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce_fall |=> (flag_r == $past(cmp_hit)))
        else $error("compare flag not latched at select");

    idle_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        ce_fall |=> (cpol_r == $past(sck_f)) ##1 $stable(cpol_r))
        else $error("clock idle level not latched");

    write_float_a: assert property (@(posedge clk) disable iff (sys_rst)
        wr_fire |=> (!miso_oe && st_r == sio_pkg::SIO_ST_DONE)[*2])
        else $error("output not floated after write");

    mask_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_fire && !tgt_dir_r && fmt_r == sio_pkg::SIO_FMT_SET)
        |=> ((data_r & $past(sh_in_nxt)) == $past(sh_in_nxt)))
        else $error("set mask did not set bits");

    mask_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_fire && tgt_dir_r && fmt_r == sio_pkg::SIO_FMT_CLEAR)
        |=> ((dir_r & $past(sh_in_nxt)) == 8'h00) && ((dir_r | $past(sh_in_nxt))
        == ($past(dir_r) | $past(sh_in_nxt))))
        else $error("clear mask wrong");

    id_miss_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_done && !id_hit) |=> (st_r == sio_pkg::SIO_ST_DONE) ##1 !miso_oe)
        else $error("mismatched device took part");

    read_pins_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_done && id_hit && !ctrl.target_select)
        |=> ((sh_out_r & ~dir_r) == ($past(pins_f) & ~dir_r)))
        else $error("read did not load pin levels");

    direct_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_fire && !fmt_r[1]) |=> ((tgt_dir_r ? dir_r : data_r) == $past(sh_in_nxt)))
        else $error("direct write not applied");

    flag_out_a: assert property (@(posedge clk) disable iff (sys_rst)
        (sel && drive_ctrl) |=> (miso_oe && (miso_o == $past(flag_r))))
        else $error("compare flag not shifted out");

    ident_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
        (in_ctrl && !id_ok_r) |-> !miso_oe)
        else $error("output driven before identify match");

    bit_step_a: assert property (@(posedge clk) disable iff (sys_rst)
        (sel && (in_ctrl || in_data) && trail)
        |=> (bit_cnt_r == 3'($past(bit_cnt_r) + 3'h1)))
        else $error("bit counter did not step");

    desel_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
        !sel |=> (st_r == sio_pkg::SIO_ST_IDLE && bit_cnt_r == 3'h0))
        else $error("serial state kept while deselected");

    read_stream_a: assert property (@(posedge clk) disable iff (sys_rst)
        (data_done && !wr_r) |=> (sh_out_r == $past(cur_tgt)))
        else $error("read did not reload register");

    old_value_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ctrl_done && id_hit && ctrl.target_select) |=> (sh_out_r == $past(dir_r)))
        else $error("direction value not loaded for shift");

    flag_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ce_fall |=> $stable(flag_r))
        else $error("compare flag moved outside select");

    idle_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
        !ce_fall |=> $stable(cpol_r))
        else $error("idle level moved outside select");
endmodule

// [testbench/sio_spi_master.sv]
// Behavioural SPI master facing the serial port; clock phase 1, either idle level.
// Assumes the bench calls frame, then deselect; its timing is free of the system clock.
`timescale 1ns/1ps
module sio_spi_master #(
    parameter int HALF = 80,
    parameter int LATE = 50
) (
    output logic sck,
    output logic mosi,
    output logic ce_n,
    input wire logic miso
);
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        ce_n = 1'b1;
    end

    // ==========================================
    // Frame: clock parked at idle before select
    // Late sample: the port answers a few system clocks after the leading edge
    task automatic frame(input logic cpol, input int nbits, input logic [23:0] tx,
                         output logic [23:0] rx);
        rx = '0;
        // Off the clk edge, so no pin change races a sampling flop
        #3;
        sck = cpol;
        #(2 * HALF);
        ce_n = 1'b0;
        #(2 * HALF);
        for (int i = 0; i < nbits; i++) begin
            sck = ~cpol;
            mosi = tx[23 - i];
            #HALF;
            sck = cpol;
            #LATE;
            rx[23 - i] = miso;
            #(HALF - LATE);
        end
    endtask

    // ==========================================
    // Release: data line shows no stale level
    task automatic deselect();
        #(HALF + 3);
        ce_n = 1'b1;
        mosi = ~mosi;
        #(2 * HALF);
    endtask
endmodule

// [testbench/tb_sio_port.sv]
// Self-checking bench for sio_port: SPI master model, local register port, pin model.
// Assumes the hand-over contract: 50 MHz clk, link sampled by clk, reads one cycle late.
`timescale 1ns/1ps
module tb_sio_port;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] idn = 2'h2;
    logic [7:0] ext = 8'h00;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [7:0] reg_rdata, port_pins_o, port_pins_oe, port_pins_i;
    wire sck, mosi, ce_n, miso_o, miso_oe, miso;
    logic miso_hold = 1'b0;
    logic oe_seen = 1'b0;
    logic oe_clr = 1'b0;
    int seed = 17570;
    int failures = 0;
    int samples_checked = 0;
    logic [7:0] lat_m = 8'h00;
    logic [7:0] dir_m = 8'h00;
    logic [1:0] mode_m = 2'h0;
    logic ctl_en = 1'b1;

    always #10 clk = ~clk;
    // Released serial out shows the inverse of its last level
    always @(posedge clk) if (miso_oe) miso_hold <= miso_o;
    always @(posedge clk) oe_seen <= oe_clr ? 1'b0 : (oe_seen | (miso_oe === 1'b1));
    assign miso = miso_oe ? miso_o : ~miso_hold;
    // Output pins carry the latch, input pins the outside level
    assign port_pins_i = (port_pins_o & port_pins_oe) | (ext & ~port_pins_oe);

    sio_port dut (.clk(clk), .sys_rst(sys_rst), .sck(sck), .mosi(mosi), .ce_n(ce_n),
        .chip_ident_msb(idn[1]), .chip_ident_lsb(idn[0]), .miso_o(miso_o),
        .miso_oe(miso_oe), .port_pins_i(port_pins_i), .port_pins_o(port_pins_o),
        .port_pins_oe(port_pins_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    sio_spi_master master (.sck(sck), .mosi(mosi), .ce_n(ce_n), .miso(miso));

    // ==========================================
    // Compares and verdict
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================
    // Local register port
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // ==========================================
    // Reference model
    function automatic logic [7:0] rd_val();
        return (ext & ~dir_m) | (lat_m & dir_m);
    endfunction
    function automatic logic cmp_flag(input logic [1:0] m);
        logic [7:0] eq;
        eq = ~(ext ^ lat_m) | dir_m;
        case (m)
            2'h0: return eq != 8'hff;
            2'h1: return eq == 8'hff;
            2'h2: return eq == 8'h00;
            default: return eq != 8'h00;
        endcase
    endfunction

    // One selected access; a frame shorter than 16 bits is cut off by deselect
    task automatic access(input logic [1:0] id, input logic tgt, input logic wr,
                          input logic [1:0] fmt, input logic [1:0] cm, input logic [7:0] wd,
                          input logic cpol, input int nbits);
        logic [23:0] rx;
        logic [7:0] rdv, nv, rv;
        logic flag, hit, full;
        oe_clr <= 1'b1;
        repeat (2) @(posedge clk);
        oe_clr <= 1'b0;
        rdv = tgt ? dir_m : rd_val();
        flag = cmp_flag(mode_m);
        hit = (id === idn) && ctl_en;
        full = nbits >= 16;
        master.frame(cpol, nbits, {id, tgt, wr, fmt, cm, wd, wd}, rx);
        repeat (6) @(posedge clk);
        check_bit("serial out enable", hit && !(wr && full), miso_oe);
        master.deselect();
        check_bit("serial out ever driven", hit, oe_seen);
        if (hit) begin
            check_byte("compare info", {2'h0, {6{flag}}}, {2'h0, rx[21:16]});
        end
        if (hit && full) begin
            check_byte("shifted register value", rdv, rx[15:8]);
        end
        if (hit && nbits > 16) begin
            check_byte("streamed read", rdv, rx[7:0]);
        end
        if (hit) begin
            mode_m = cm;
        end
        if (hit && wr && full) begin
            nv = tgt ? dir_m : lat_m;
            case (fmt)
                2'h2: nv = nv & ~wd;
                2'h3: nv = nv | wd;
                default: nv = wd;
            endcase
            if (tgt) begin
                dir_m = nv;
            end else begin
                lat_m = nv;
            end
        end
        repeat (4) @(posedge clk);
        check_byte("pin drive enables", dir_m, port_pins_oe);
        check_byte("pin drive values", lat_m, port_pins_o);
        reg_read(sio_pkg::SIO_OFS_DATA, rv);
        check_byte("local data read", rd_val(), rv);
        reg_read(sio_pkg::SIO_OFS_DIR, rv);
        check_byte("local direction read", dir_m, rv);
        if (ctl_en) begin
            reg_read(sio_pkg::SIO_OFS_STAT, rv);
            check_byte("latched flag and idle", {6'h0, cpol, flag}, {6'h0, rv[1:0]});
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        logic [7:0] d;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        check_byte("enables after reset", 8'h00, port_pins_oe);
        reg_read(sio_pkg::SIO_OFS_DIR, d);
        check_byte("direction after reset", 8'h00, d);
        reg_read(sio_pkg::SIO_OFS_CTL, d);
        check_bit("link enable after reset", 1'b1, d[0]);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            ext <= 8'($random(seed));
            access(idn, i[0], 1'b1, 2'(i >> 2), 2'(i), 8'($random(seed)), i[2], 16);
        end
        $display("test write formats done");
        access(idn, 1'b1, 1'b1, 2'h0, 2'h0, 8'h0f, 1'b0, 16);
        for (int i = 0; i < 8; i++) begin
            case (i % 4)
                0: ext <= lat_m;
                1: ext <= ~lat_m;
                2: ext <= 8'($random(seed));
                default: ext <= lat_m ^ 8'h80;
            endcase
            access(idn, i[2], 1'b0, 2'h0, 2'(i), 8'h00, i[0], 24);
        end
        $display("test reads and compare done");
        for (int i = 1; i < 4; i++) begin
            access(idn ^ 2'(i), 1'(i), 1'b1, 2'h0, 2'(i), 8'($random(seed)), i[0], 16);
        end
        access(idn, 1'b0, 1'b1, 2'h0, 2'h2, 8'h3c, 1'b1, 12);
        $display("test ident and abort done");
        reg_write(sio_pkg::SIO_OFS_CTL, 8'h00);
        ctl_en = 1'b0;
        access(idn, 1'b1, 1'b1, 2'h0, 2'h1, 8'h5a, 1'b0, 16);
        reg_write(sio_pkg::SIO_OFS_DIR, 8'hff);
        reg_write(sio_pkg::SIO_OFS_CTL, 8'h01);
        ctl_en = 1'b1;
        access(idn, 1'b1, 1'b0, 2'h0, 2'h3, 8'h00, 1'b1, 16);
        $display("test link off and read-only done");
        print_verdict();
    end

    // Whole run is near 120 us; far past that counts as a hang
    initial begin
        #1000000;
        failures++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule
